// ---- src/ldc_capture.sv ----
`default_nettype none
`include "ldc_map.svh"

module ldc_capture
  import ldc_pkg::*;
#(
  parameter int DATA_W     = `LDC_DATA_W,
  parameter int FIFO_DEPTH = `LDC_FIFO_DEPTH,
  parameter int DIV_RATIO  = `LDC_DIV_RATIO
) (
  // Core clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst,
  // Source pins
  input  wire logic [DATA_W-1:0]             data_pins,
  input  wire logic                          source_data_clock_pair,
  input  wire logic                          frame_indicator_pair,
  input  wire logic                          output_align_strobe,
  // Configuration
  input  wire logic                          byte_mode,
  input  wire ldc_frame_mode_t               frame_mode,
  input  wire logic                          parity_enable,
  input  wire logic                          parity_clear,
  input  wire logic                          dual_sync_mode,
  // Captured stream
  output var  ldc_word_t                     sample_q,
  output var  logic                          sample_valid_q,
  output var  ldc_edge_t                     sample_edge_q,
  // Frame events
  output var  logic                          fifo_reset_q,
  output var  logic                          sync_pulse_q,
  output var  logic                          parity_error_q,
  // Read-side alignment
  output var  logic                          align_pulse_q,
  output var  logic                          div_tick_q,
  output var  logic [$clog2(FIFO_DEPTH)-1:0] rd_ptr_q
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CNT_W = (DIV_RATIO > 1) ? $clog2(DIV_RATIO) : 1;
  localparam int SYN_W = DATA_W + 3;

  function automatic logic word_parity(input ldc_word_t w);
    word_parity = ^w;
  endfunction

  logic [SYN_W-1:0] lvl;
  logic [DATA_W-1:0] data_lvl;
  logic              dclk_lvl;
  logic              frame_lvl;
  logic              strobe_lvl;
  logic              dclk_prev_q;
  logic              strobe_prev_q;
  logic              frame_rise_prev_q;
  logic              rise_par_q;
  logic [CNT_W-1:0]  div_cnt_q;
  logic              dclk_rise;
  logic              dclk_fall;
  logic              strobe_rise;
  ldc_word_t         word_d;

  // Every pin, including the data clock, crosses into the core clock here
  ldc_pin_sync #(.W(SYN_W)) u_sync (
    .clock   (clock),
    .rst     (rst),
    .pin_in  ({output_align_strobe, frame_indicator_pair, source_data_clock_pair, data_pins}),
    .level_q (lvl)
  );

  assign data_lvl   = lvl[DATA_W-1:0];
  assign dclk_lvl   = lvl[DATA_W];
  assign frame_lvl  = lvl[DATA_W+1]; // Relies on frame being edge-aligned with data
  assign strobe_lvl = lvl[DATA_W+2];

  assign dclk_rise   = dclk_lvl & ~dclk_prev_q;
  assign dclk_fall   = ~dclk_lvl & dclk_prev_q;
  assign strobe_rise = strobe_lvl & ~strobe_prev_q; // Core-clock rising edge sample

  // Byte mode keeps bit 7 as MSB and zeroes the unused upper lanes
  always_comb begin
    word_d = data_lvl;
    if (byte_mode) begin
      word_d = {{(DATA_W-`LDC_BYTE_W){1'b0}}, data_lvl[`LDC_BYTE_MSB:0]};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dclk_prev_q   <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      dclk_prev_q   <= dclk_lvl;
      strobe_prev_q <= strobe_lvl;
    end
  end

  // Double data rate capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sample_q       <= '0;
      sample_valid_q <= 1'b0;
      sample_edge_q  <= LDC_EDGE_RISE;
    end else begin
      sample_valid_q <= dclk_rise | dclk_fall;
      if (dclk_rise | dclk_fall) begin
        sample_q      <= word_d;
        sample_edge_q <= dclk_fall ? LDC_EDGE_FALL : LDC_EDGE_RISE;
      end
    end
  end

  // Frame functions act on a 0-to-1 change between successive rising-edge samples
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_rise_prev_q <= 1'b0;
      fifo_reset_q      <= 1'b0;
      sync_pulse_q      <= 1'b0;
    end else begin
      fifo_reset_q <= 1'b0;
      sync_pulse_q <= 1'b0;
      if (dclk_rise) begin
        frame_rise_prev_q <= frame_lvl;
        if (frame_lvl && !frame_rise_prev_q) begin
          fifo_reset_q <= (frame_mode == LDC_FRAME_FIFO_RESET);
          sync_pulse_q <= (frame_mode == LDC_FRAME_SYNC);
        end
      end
    end
  end

  // Block is the rising word plus the following falling word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rise_par_q     <= 1'b0;
      parity_error_q <= 1'b0;
    end else begin
      if (dclk_rise) begin
        rise_par_q <= word_parity(word_d);
      end
      // A mismatch in the clear cycle still sets the flag
      if (dclk_fall && parity_enable &&
          (frame_lvl != (rise_par_q ^ word_parity(word_d)))) begin
        parity_error_q <= 1'b1;
      end else if (parity_clear) begin
        parity_error_q <= 1'b0;
      end
    end
  end

  // Divided clock and FIFO read pointer, realigned by the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt_q     <= CNT_W'(`LDC_CNT_RST);
      div_tick_q    <= 1'b0;
      rd_ptr_q      <= PTR_W'(`LDC_PTR_RST);
      align_pulse_q <= 1'b0;
    end else begin
      align_pulse_q <= strobe_rise & dual_sync_mode;
      div_tick_q    <= 1'b0;
      if (strobe_rise && dual_sync_mode) begin
        div_cnt_q <= CNT_W'(`LDC_CNT_RST);
        rd_ptr_q  <= PTR_W'(`LDC_PTR_RST);
      end else if (div_cnt_q == CNT_W'(DIV_RATIO - 1)) begin
        div_cnt_q  <= '0;
        div_tick_q <= 1'b1;
        rd_ptr_q   <= (rd_ptr_q == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_DDR_CAPTURE: assert property (
    (dclk_rise | dclk_fall) |=> sample_valid_q && sample_q == $past(word_d))
    else $error("data edge not captured");

  AST_BYTE_UPPER_ZERO: assert property (
    (byte_mode && dclk_rise) |=> sample_q[DATA_W-1:`LDC_BYTE_W] == '0)
    else $error("upper lanes not zero in byte mode");

  AST_FRAME_FROM_RISE: assert property (
    (fifo_reset_q | sync_pulse_q) |-> $past(dclk_rise) && $past(frame_lvl))
    else $error("frame event without rising-edge sample");

  AST_FRAME_ROUTE: assert property (
    $past(dclk_rise && frame_lvl && !frame_rise_prev_q) |->
      (fifo_reset_q == ($past(frame_mode) == LDC_FRAME_FIFO_RESET)) &&
      (sync_pulse_q == ($past(frame_mode) == LDC_FRAME_SYNC)))
    else $error("frame event routed wrongly");

  AST_PARITY_SET_CAUSE: assert property (
    $rose(parity_error_q) |-> $past(dclk_fall) && $past(parity_enable))
    else $error("parity error without falling-edge check");

  AST_PARITY_STICKY: assert property (
    (parity_error_q && !parity_clear) |=> parity_error_q)
    else $error("parity error flag lost");

  AST_PARITY_FLAGGED: assert property (
    (dclk_fall && parity_enable && (frame_lvl != (rise_par_q ^ word_parity(word_d)))) |=>
      parity_error_q)
    else $error("parity mismatch not flagged");

  AST_STROBE_ALIGN: assert property (
    align_pulse_q |-> rd_ptr_q == '0 && div_cnt_q == '0 && !div_tick_q)
    else $error("strobe did not realign");

  AST_STROBE_MODE: assert property (
    align_pulse_q |-> $past(dual_sync_mode) && $past(strobe_lvl) && !$past(strobe_prev_q))
    else $error("align without strobe edge");

endmodule

`default_nettype wire

// ---- src/ldc_map.svh ----
`ifndef LDC_MAP_SVH
`define LDC_MAP_SVH

// Capture widths
`define LDC_DATA_W      16
`define LDC_BYTE_W      8
`define LDC_BYTE_MSB    7
`define LDC_WORD_MSB    15

// Read side of the input FIFO
`define LDC_FIFO_DEPTH  8
`define LDC_DIV_RATIO   4

// Reset values
`define LDC_PTR_RST     0
`define LDC_CNT_RST     0

`endif

// ---- src/ldc_pin_sync.sv ----
`default_nettype none

// Three-stage pin synchroniser; an output bit follows once stages two and three agree
module ldc_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Pins and stable levels
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        level_q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        level_q[i] <= s3_q[i];
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/ldc_pkg.sv ----
`default_nettype none
`include "ldc_map.svh"

package ldc_pkg;

  typedef logic [`LDC_DATA_W-1:0] ldc_word_t;

  typedef enum logic {
    LDC_FRAME_FIFO_RESET,
    LDC_FRAME_SYNC
  } ldc_frame_mode_t;

  typedef enum logic {
    LDC_EDGE_RISE,
    LDC_EDGE_FALL
  } ldc_edge_t;

endpackage

`default_nettype wire

// ---- verification/ldc_src_model.sv ----
`default_nettype none

// Far-side source: one call per data clock edge, always starting on a rising edge
module ldc_src_model (
  // Core clock
  input  wire logic        clock,
  // Source pins
  output var  logic [15:0] data_pins,
  output var  logic        dclk,
  output var  logic        frame
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    data_pins = 16'h0000;
    dclk      = 1'b0;
    frame     = 1'b0;
  end

  task automatic edge_out(input logic [15:0] w, input logic f);
    @(posedge clock);
    data_pins <= w;
    frame     <= f;
    dclk      <= ~dclk;
  endtask

  // Bus released after a block: stale levels must not look valid
  task automatic release_bus();
    @(posedge clock);
    data_pins <= ~data_pins;
  endtask
endmodule

`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none

module tb_top
  import ldc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;

  logic            clock, rst, strobe, byte_mode, parity_enable, parity_clear, dual_sync_mode;
  logic [15:0]     src_data;
  logic            dclk, frame, valid, fifo_rst, sync_p, par_err, align, div_tick;
  ldc_frame_mode_t frame_mode;
  ldc_word_t       sample;
  ldc_edge_t       edge_q;
  logic [2:0]      rd_ptr;
  int              num_errors, compares;

  ldc_src_model u_ldc_src_model (.clock(clock), .data_pins(src_data), .dclk(dclk), .frame(frame));

  ldc_capture #(.DIV_RATIO(DIV)) u_ldc_capture (
    .clock(clock), .rst(rst), .data_pins(src_data), .source_data_clock_pair(dclk),
    .frame_indicator_pair(frame), .output_align_strobe(strobe), .byte_mode(byte_mode),
    .frame_mode(frame_mode), .parity_enable(parity_enable), .parity_clear(parity_clear),
    .dual_sync_mode(dual_sync_mode), .sample_q(sample), .sample_valid_q(valid),
    .sample_edge_q(edge_q), .fifo_reset_q(fifo_rst), .sync_pulse_q(sync_p),
    .parity_error_q(par_err), .align_pulse_q(align), .div_tick_q(div_tick), .rd_ptr_q(rd_ptr));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Bounded wait for a one-cycle pulse of valid or align; leaves time just after the pulse edge
  task automatic wait_hi(input bit on_align);
    int i;
    i = 0;
    tick(1);
    while ((on_align ? align : valid) !== 1'b1 && i < 12) begin
      tick(1);
      i++;
    end
    if (i == 12) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  endtask

  task automatic send_block(input logic [15:0] a, b, input logic fr, fb, ev);
    logic [15:0] m;
    logic [1:0]  fe;
    m = byte_mode ? 16'h00FF : 16'hFFFF;
    u_ldc_src_model.edge_out(a, fr);
    wait_hi(1'b0);
    // Mode is read here, after any same-edge update by the caller has settled
    fe = {ev && frame_mode == LDC_FRAME_FIFO_RESET, ev && frame_mode == LDC_FRAME_SYNC};
    check(sample, a & m);
    check(16'(edge_q), 16'(LDC_EDGE_RISE));
    check(16'({fifo_rst, sync_p}), 16'(fe));
    tick(1);
    check(16'(valid), 16'h0000);
    tick(1);
    u_ldc_src_model.edge_out(b, fb);
    wait_hi(1'b0);
    check(sample, b & m);
    check(16'({edge_q, fifo_rst, sync_p}), 16'h0004);
    tick(1);
    check(16'(valid), 16'h0000);
    tick(1);
  endtask

  task automatic test_frame(input ldc_frame_mode_t md);
    @(posedge clock);
    frame_mode <= md;
    // Falling frame high while rising stays low: no frame event allowed
    send_block(16'h0001, 16'h0000, 1'b0, 1'b1, 1'b0);
    send_block(16'h8000, 16'h1234, 1'b1, 1'b0, 1'b1);
    check(16'(par_err), 16'h0000);
    $display("frame test mode %0d done", md);
  endtask

  task automatic test_parity();
    @(posedge clock);
    parity_enable <= 1'b0;
    send_block(16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b0);
    check(16'(par_err), 16'h0000);
    @(posedge clock);
    parity_enable <= 1'b1;
    send_block(16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b0);
    check(16'(par_err), 16'h0001);
    @(posedge clock);
    parity_clear <= 1'b1;
    @(posedge clock);
    parity_clear <= 1'b0;
    byte_mode    <= 1'b1;
    tick(1);
    check(16'(par_err), 16'h0000);
    // Upper byte would flip the parity if it were not masked
    send_block(16'hA4C3, 16'h7E01, 1'b0, 1'b1, 1'b0);
    check(16'(par_err), 16'h0000);
    u_ldc_src_model.release_bus();
    @(posedge clock);
    byte_mode <= 1'b0;
    $display("parity test done");
  endtask

  task automatic test_strobe();
    logic [2:0] p;
    logic       seen;
    @(posedge clock);
    dual_sync_mode <= 1'b1;
    strobe         <= 1'b1;
    wait_hi(1'b1);
    check(16'({rd_ptr, div_tick}), 16'h0000);
    // Counter restarts at zero, so the first tick lands DIV edges after the align pulse
    tick(DIV);
    check(16'(div_tick), 16'h0001);
    check(16'(rd_ptr), 16'h0001);
    p = rd_ptr;
    tick(DIV);
    check(16'(div_tick), 16'h0001);
    check(16'(rd_ptr), 16'(p + 3'h1));
    @(posedge clock);
    strobe <= 1'b0;
    tick(4);
    @(posedge clock);
    dual_sync_mode <= 1'b0;
    strobe         <= 1'b1;
    seen = 1'b0;
    repeat (10) begin
      tick(1);
      seen = seen | align;
    end
    check(16'(seen), 16'h0000);
    $display("strobe test done");
  endtask

  initial begin
    num_errors = 0;
    compares = 0;
    rst = 1'b1;
    strobe = 1'b0;
    byte_mode = 1'b0;
    parity_enable = 1'b1;
    parity_clear = 1'b0;
    dual_sync_mode = 1'b0;
    frame_mode = LDC_FRAME_FIFO_RESET;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    tick(5);
    test_frame(LDC_FRAME_FIFO_RESET);
    test_frame(LDC_FRAME_SYNC);
    test_parity();
    test_strobe();
    finish_test();
  end
endmodule

`default_nettype wire
